// ### dsy_cfg.sv
// desync transmit configuration bank with gapped clock capture
//
// Summary of operation
// - line control at 0x06, 0x0E, 0x16
// - jitter control at 0x07, 0x0F, 0x17
// - rail strap high selects single-rail input
// - jitter bits: 7-5 zero, 4 recovery, 3 reset
// - bw low one, bw high zero: narrow
// - path bit or strap high: transmit direction
// - recovery bit zero enables fast recovery mode
// - strap mode always keeps fast recovery enabled
// - survive 59 empty slots without losing lock
// - latch data on gapped clock edge
// - both rate selects zero gives DS3 rate
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "dsy_regs.svh"
module dsy_cfg import dsy_pkg::*; #(
   parameter int NCH = 3,
   // cycles per bit slot, rounded up, at least one
   parameter int SLOT_CYC = (`DSY_SLOT_PS + `DSY_CLK_PS - 1) / `DSY_CLK_PS
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_host_mode,
   input wire logic [NCH-1:0] i_rail_format_select,
   input wire logic [NCH-1:0] i_low_rate_select,
   input wire logic [NCH-1:0] i_sonet_rate_select,
   input wire logic [NCH-1:0] i_bandwidth_select_low,
   input wire logic [NCH-1:0] i_bandwidth_select_high,
   input wire logic [NCH-1:0] i_attenuator_path_select,
   input wire logic [NCH-1:0] i_tx_gapped_clock_in,
   input wire logic [NCH-1:0] i_tx_line_data_in,
   output logic [NCH-1:0] o_line_data,
   output logic [NCH-1:0] o_line_strobe,
   output logic [NCH-1:0] o_locked,
   output logic [NCH-1:0] o_single_rail,
   output logic [NCH-1:0] o_ds3_mode,
   output logic [NCH-1:0] o_e3_mode,
   output logic [NCH-1:0] o_sts1_mode,
   output logic [NCH-1:0] o_far_loopback_enable,
   output logic [NCH-1:0] o_near_loopback_enable,
   output logic [NCH-1:0] o_test_pattern_enable,
   output logic [NCH-1:0] o_narrow_bw,
   output logic [NCH-1:0] o_tx_path,
   output logic [NCH-1:0] o_attenuator_block_reset,
   output logic [NCH-1:0] o_fast_recovery_on
);

   // ----------------------------------------
   // constants
   // ----------------------------------------
   // longest tolerated silence, one slot of slack beyond the gap
   // at the default slot length this is 120 register clocks
   localparam int GAP_CYC = (`DSY_GAP_SLOTS + 1) * SLOT_CYC;
   // counter wide enough to reach the ceiling without wrapping
   localparam int GW = $clog2(GAP_CYC + 1);
   localparam int SW = 1 + 6 * NCH; // strap bundle width

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   dsy_byte_t line_q [NCH]; // line control per channel
   dsy_byte_t jit_q [NCH]; // jitter control per channel
   logic [SW-1:0] strap_s1_q; // strap synchroniser stage 1
   logic [SW-1:0] strap_s2_q; // strap synchroniser stage 2
   logic host_q; // synchronised host mode
   // synchronised strap levels, one bit per channel
   // only these are read by the channel logic, never the raw pins
   logic [NCH-1:0] rail_st, low_st, sonet_st, bwl_st, bwh_st, path_st;

   // ----------------------------------------
   // strap synchroniser
   // ----------------------------------------
   // pins are asynchronous: two flops before any use
   // host mode travels in the same bundle, so a mode change and the
   // strap levels it selects reach the channels in the same cycle
   // straps are slow levels: a bit caught mid-change settles a cycle later
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_s1_q <= '0;
         strap_s2_q <= '0;
      end else begin
         strap_s1_q <= {i_host_mode, i_rail_format_select, i_low_rate_select, i_sonet_rate_select,
                        i_bandwidth_select_low, i_bandwidth_select_high, i_attenuator_path_select};
         strap_s2_q <= strap_s1_q;
      end
   end

   // unpack the synchronised bundle
   // field order matches the packing above
   assign {host_q, rail_st, low_st, sonet_st, bwl_st, bwh_st, path_st} = strap_s2_q;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // offsets decoded per channel; unused bits masked off
   // masking on the way in means reads need no mask of their own
   // writes to status or any unmapped address change nothing
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NCH; c++) begin
            line_q[c] <= `DSY_LINE_RST;
            jit_q[c] <= `DSY_JIT_RST;
         end
      end else if (i_wr) begin
         if (i_addr == `DSY_LINE_CH0) begin
            line_q[0] <= i_wdata & `DSY_LC_MASK;
         end else if (i_addr == `DSY_LINE_CH1) begin
            line_q[1] <= i_wdata & `DSY_LC_MASK;
         end else if (i_addr == `DSY_LINE_CH2) begin
            line_q[2] <= i_wdata & `DSY_LC_MASK;
         end else if (i_addr == `DSY_JIT_CH0) begin
            jit_q[0] <= i_wdata & `DSY_JC_MASK;
         end else if (i_addr == `DSY_JIT_CH1) begin
            jit_q[1] <= i_wdata & `DSY_JC_MASK;
         end else if (i_addr == `DSY_JIT_CH2) begin
            jit_q[2] <= i_wdata & `DSY_JC_MASK;
         end
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   // data stands one cycle after the strobe only
   // the bus is zero whenever no read was asked for, so a stale
   // value can never be mistaken for a fresh answer
   // status is rebuilt at each read, so lock seen there is current
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else if (!i_rd) begin
         o_rdata <= '0; // idle bus reads zero
      end else if (i_addr == `DSY_LINE_CH0) begin
         o_rdata <= line_q[0];
      end else if (i_addr == `DSY_LINE_CH1) begin
         o_rdata <= line_q[1];
      end else if (i_addr == `DSY_LINE_CH2) begin
         o_rdata <= line_q[2];
      end else if (i_addr == `DSY_JIT_CH0) begin
         o_rdata <= jit_q[0];
      end else if (i_addr == `DSY_JIT_CH1) begin
         o_rdata <= jit_q[1];
      end else if (i_addr == `DSY_JIT_CH2) begin
         o_rdata <= jit_q[2];
      end else if (i_addr == `DSY_STATUS) begin
         // lock per channel, host mode at bit 7
         o_rdata <= {host_q, 4'h0, o_locked};
      end else begin
         o_rdata <= '0; // unmapped address
      end
   end

   // ----------------------------------------
   // per channel logic
   // ----------------------------------------
   // crossing: the link clock only flips a toggle and holds the bit;
   // the register clock sees the toggle after two flops, by which time
   // the bit has stood still for most of a link period, so it is taken
   // with no synchroniser of its own
   // limitation: link edges closer than about four register clocks
   // are merged and a bit is lost
   // one copy of this logic per channel
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic rail_d, sonet_d, low_d, bwl_d, bwh_d, path_d; // effective selects
      logic cap_q; // bit latched in link domain
      logic tog_q; // flips once per captured bit
      logic tog_s1_q, tog_s2_q, tog_s3_q; // toggle crossing
      logic [GW-1:0] gap_q; // cycles since last bit
      logic bit_ev; // one new bit seen

      // host registers or synchronised straps
      // selects follow the synchronised mode, never the raw pin
      always_comb begin
         if (host_q) begin
            rail_d = line_q[g][`DSY_LC_RAIL];
            sonet_d = line_q[g][`DSY_LC_SONET];
            low_d = line_q[g][`DSY_LC_LOWRATE];
            bwl_d = jit_q[g][`DSY_JC_BWLOW];
            bwh_d = jit_q[g][`DSY_JC_BWHIGH];
            path_d = jit_q[g][`DSY_JC_PATH];
         end else begin
            rail_d = rail_st[g];
            sonet_d = sonet_st[g];
            low_d = low_st[g];
            bwl_d = bwl_st[g];
            bwh_d = bwh_st[g];
            path_d = path_st[g];
         end
      end

      // configuration outputs, registered
      // rate decode: low rate wins when both rate selects are set
      // strap mode has no loopback, test pattern or block reset pins
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            o_single_rail[g] <= 1'b0;
            o_ds3_mode[g] <= 1'b0;
            o_e3_mode[g] <= 1'b0;
            o_sts1_mode[g] <= 1'b0;
            o_far_loopback_enable[g] <= 1'b0;
            o_near_loopback_enable[g] <= 1'b0;
            o_test_pattern_enable[g] <= 1'b0;
            o_narrow_bw[g] <= 1'b0;
            o_tx_path[g] <= 1'b0;
            o_attenuator_block_reset[g] <= 1'b0;
            o_fast_recovery_on[g] <= 1'b0;
         end else begin
            o_single_rail[g] <= rail_d;
            o_ds3_mode[g] <= !low_d && !sonet_d;
            o_e3_mode[g] <= low_d;
            o_sts1_mode[g] <= sonet_d && !low_d;
            // loopbacks and test pattern exist only in host mode
            o_far_loopback_enable[g] <= host_q && line_q[g][`DSY_LC_FARLB];
            o_near_loopback_enable[g] <= host_q && line_q[g][`DSY_LC_NEARLB];
            o_test_pattern_enable[g] <= host_q && line_q[g][`DSY_LC_TEST];
            o_narrow_bw[g] <= bwl_d && !bwh_d;
            o_tx_path[g] <= path_d;
            o_attenuator_block_reset[g] <= host_q && jit_q[g][`DSY_JC_BRST];
            // disable bit honoured only in host mode
            o_fast_recovery_on[g] <= !(host_q && jit_q[g][`DSY_JC_FRDIS]);
         end
      end

      // link domain: latch data on rising gapped clock
      // asynchronous reset clears this side even with no link clock
      always_ff @(posedge i_tx_gapped_clock_in[g] or negedge i_rst_n) begin
         if (!i_rst_n) begin
            cap_q <= 1'b0;
            tog_q <= 1'b0;
         end else begin
            cap_q <= i_tx_line_data_in[g];
            tog_q <= ~tog_q;
         end
      end

      // toggle crossing into the register clock
      // the third stage only remembers the last level for edge detect
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
         end else begin
            tog_s1_q <= tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
         end
      end

      // edge of the synchronised toggle marks a new bit
      assign bit_ev = tog_s2_q ^ tog_s3_q;

      // captured bit is held a whole link period, safe to take here
      // strobe and data leave together, so a watcher may take both at once
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            o_line_data[g] <= 1'b0;
            o_line_strobe[g] <= 1'b0;
         end else begin
            o_line_strobe[g] <= bit_ev;
            if (bit_ev) begin
               o_line_data[g] <= cap_q;
            end
         end
      end

      // lock follows bits; a 59 slot silence is tolerated
      // gap_q counts register clocks since the last bit and saturates,
      // so a long idle link stays unlocked without wrapping
      // block reset wins over a bit arriving in the same cycle
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            gap_q <= '0;
            o_locked[g] <= 1'b0;
         end else if (o_attenuator_block_reset[g]) begin
            gap_q <= '0; // block reset drops lock
            o_locked[g] <= 1'b0;
         end else if (bit_ev) begin
            gap_q <= '0;
            o_locked[g] <= 1'b1;
         end else if (gap_q < GW'(GAP_CYC)) begin
            gap_q <= gap_q + 1'b1;
         end else begin
            o_locked[g] <= 1'b0; // silence beyond tolerance
         end
      end
   end

endmodule : dsy_cfg

// ### dsy_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DSY_REGS_SVH
`define DSY_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DSY_LINE_CH0 8'h06
`define DSY_LINE_CH1 8'h0E
`define DSY_LINE_CH2 8'h16
`define DSY_JIT_CH0 8'h07
`define DSY_JIT_CH1 8'h0F
`define DSY_JIT_CH2 8'h17
`define DSY_STATUS 8'h20
// ----------------------------------------
// line control fields
// ----------------------------------------
`define DSY_LC_RAIL 0
`define DSY_LC_SONET 1
`define DSY_LC_LOWRATE 2
`define DSY_LC_NEARLB 3
`define DSY_LC_FARLB 4
`define DSY_LC_TEST 5
`define DSY_LC_MASK 8'h3F
// ----------------------------------------
// jitter control fields
// ----------------------------------------
`define DSY_JC_BWLOW 0
`define DSY_JC_PATH 1
`define DSY_JC_BWHIGH 2
`define DSY_JC_BRST 3
`define DSY_JC_FRDIS 4
`define DSY_JC_MASK 8'h1F
// ----------------------------------------
// reset values
// ----------------------------------------
`define DSY_LINE_RST 8'h00
`define DSY_JIT_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define DSY_CLK_PS 10000
`define DSY_SLOT_PS 19300
`define DSY_GAP_SLOTS 59
`endif

// ### dsy_pkg.sv
// types shared by the desync configuration block
package dsy_pkg;
   typedef logic [7:0] dsy_byte_t; // one register byte
   typedef logic [2:0] dsy_chan_t; // one bit per channel
endpackage : dsy_pkg

// ### dsy_cfg_properties.sv
// port checker for the desync configuration bank
`timescale 1ns/10ps
`include "dsy_regs.svh"
module dsy_cfg_properties #(
   parameter int NCH = 3,
   parameter int SLOT_CYC = 2
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_host_mode,
   input wire logic [NCH-1:0] i_rail_format_select,
   input wire logic [NCH-1:0] i_low_rate_select,
   input wire logic [NCH-1:0] i_sonet_rate_select,
   input wire logic [NCH-1:0] i_bandwidth_select_low,
   input wire logic [NCH-1:0] i_bandwidth_select_high,
   input wire logic [NCH-1:0] i_attenuator_path_select,
   input wire logic [NCH-1:0] o_line_strobe,
   input wire logic [NCH-1:0] o_locked,
   input wire logic [NCH-1:0] o_single_rail,
   input wire logic [NCH-1:0] o_ds3_mode,
   input wire logic [NCH-1:0] o_narrow_bw,
   input wire logic [NCH-1:0] o_tx_path,
   input wire logic [NCH-1:0] o_fast_recovery_on
);
   localparam int GAP_MIN = 59 * SLOT_CYC; // silence a lock must ride out
   wire logic [6*NCH:0] straps = {i_host_mode, i_rail_format_select, i_low_rate_select, i_sonet_rate_select,
      i_bandwidth_select_low, i_bandwidth_select_high, i_attenuator_path_select}; // all strap levels
   logic [6*NCH:0] strap_q; // previous strap sample
   logic [2:0] quiet_q; // cycles straps held still
   logic [15:0] silent_q; // cycles since channel 0 bit
   // straps must also match the last sample: the counter lags a new level by one cycle
   wire logic strap_ok = !i_host_mode && straps == strap_q && quiet_q >= 3'd4; // strap mode, levels settled
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_q <= '0;
         quiet_q <= 3'h0;
         silent_q <= 16'h0000;
      end else begin
         strap_q <= straps;
         quiet_q <= (straps != strap_q) ? 3'h0 : quiet_q + 3'(quiet_q != 3'h7);
         silent_q <= o_line_strobe[0] ? 16'h0000 : silent_q + 16'(silent_q != 16'hFFFF);
      end
   end
   default clocking dflt_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_line_unused_zero: assert property ($past(i_rd) && ($past(i_addr) inside {`DSY_LINE_CH0, `DSY_LINE_CH1,
      `DSY_LINE_CH2}) |-> o_rdata[7:6] == 2'b00) else $error("line control unused bits not zero");
   a_jit_unused_zero: assert property ($past(i_rd) && ($past(i_addr) inside {`DSY_JIT_CH0, `DSY_JIT_CH1,
      `DSY_JIT_CH2}) |-> o_rdata[7:5] == 3'b000) else $error("jitter control unused bits not zero");
   a_unmapped_zero: assert property ($past(i_rd) && !($past(i_addr) inside {`DSY_LINE_CH0, `DSY_LINE_CH1,
      `DSY_LINE_CH2, `DSY_JIT_CH0, `DSY_JIT_CH1, `DSY_JIT_CH2, `DSY_STATUS}) |-> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_strap_rail: assert property (strap_ok |-> o_single_rail == i_rail_format_select)
      else $error("single rail differs from strap");
   a_strap_rate: assert property (strap_ok |-> o_ds3_mode == ~(i_low_rate_select | i_sonet_rate_select))
      else $error("rate mode differs from straps");
   a_strap_bw: assert property (strap_ok |-> o_narrow_bw == (i_bandwidth_select_low & ~i_bandwidth_select_high))
      else $error("narrow bandwidth differs from straps");
   a_strap_path: assert property (strap_ok |-> o_tx_path == i_attenuator_path_select)
      else $error("path differs from strap");
   a_strap_recovery: assert property (strap_ok |-> &o_fast_recovery_on)
      else $error("fast recovery off in strap mode");
   a_strobe_single: assert property (o_line_strobe[0] |=> !o_line_strobe[0])
      else $error("bit strobe longer than one cycle");
   a_lock_on_bit: assert property (o_line_strobe[0] ##1 o_line_strobe[0] == 1'b0 |-> o_locked[0])
      else $error("no lock after captured bit");
   a_lock_gap_hold: assert property ($fell(o_locked[0]) |-> silent_q >= GAP_MIN)
      else $error("lock lost within a legal gap");
endmodule : dsy_cfg_properties
bind dsy_cfg dsy_cfg_properties #(.NCH(NCH), .SLOT_CYC(SLOT_CYC)) dsy_cfg_properties_inst (.*);

// ### dsy_mapper.sv
// behavioural mapper sending a pre-processed gapped clock and data
`timescale 1ns/10ps
module dsy_mapper (
   input wire logic i_lclk,
   input wire logic i_run,
   input wire logic i_long_gap,
   input wire logic i_bit,
   output logic o_gclk,
   output logic o_data
);
   int len = 7; // pulses in this minor pattern
   int pos = 0; // pulses sent in this minor
   int nmin = 0; // minor index within the major
   int gap = 0; // extra empty slots pending
   int nmaj = 0; // major index: two of pattern A, then one of B
   logic en = 1'b0; // current slot carries a pulse
   logic req = 1'b0; // long gap asked for
   // one base clock period per pulse; clock stands still in gap slots
   assign o_gclk = i_lclk & en;
   initial o_data = 1'b0;
   always @(posedge i_long_gap) req = 1'b1;
   // slot decided at the falling base edge so the gated clock never glitches
   always @(negedge i_lclk) begin
      en = 1'b0;
      if (i_run && gap > 0) begin
         gap--;
      end else if (i_run && pos == len) begin
         en = (len == 6); // six pulse minor closing pattern B has no gap slot
         pos = en ? 1 : 0;
         if (nmin == 98) nmaj = (nmaj == 2) ? 0 : nmaj + 1;
         nmin = (nmin == 98) ? 0 : nmin + 1;
         len = (nmin < 63) ? 7 : (nmaj == 2 && nmin == 98) ? 6 : 5;
         gap = req ? 58 : 0;
         req = 1'b0;
         if (en) o_data = i_bit;
      end else if (i_run) begin
         en = 1'b1;
         pos++;
         o_data = i_bit;
      end
   end
endmodule : dsy_mapper

// ### tb.sv
// self-checking bench for the desync configuration bank
`timescale 1ns/10ps
`include "dsy_regs.svh"
module tb import dsy_pkg::*; ;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_host_mode = 1'b1;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
   logic [2:0] i_rail_format_select = '0, i_low_rate_select = '0, i_sonet_rate_select = '0;
   logic [2:0] i_bandwidth_select_low = '0, i_bandwidth_select_high = '0, i_attenuator_path_select = '0;
   logic lclk = 1'b0, run = 1'b0, long_gap = 1'b0, rd_d = 1'b0, gclk, gdata;
   wire logic [2:0] i_tx_gapped_clock_in = {3{gclk}};
   wire logic [2:0] i_tx_line_data_in = {3{gdata}};
   logic [2:0] o_line_data, o_line_strobe, o_locked, o_single_rail, o_ds3_mode, o_e3_mode, o_sts1_mode;
   logic [2:0] o_far_loopback_enable, o_near_loopback_enable, o_test_pattern_enable, o_narrow_bw, o_tx_path;
   logic [2:0] o_attenuator_block_reset, o_fast_recovery_on;
   logic [31:0] seed = 32'h277e_c8bb, bseed = 32'h277e_c8bb;
   int n_mismatch = 0, tests_run = 0, nb = 0, cyc = 0, c;
   dsy_byte_t q_rd[$], v, w;
   logic q_bit[$];
   logic bq; // oldest expected link bit
   localparam dsy_byte_t LADDR[3] = '{`DSY_LINE_CH0, `DSY_LINE_CH1, `DSY_LINE_CH2};
   localparam dsy_byte_t JADDR[3] = '{`DSY_JIT_CH0, `DSY_JIT_CH1, `DSY_JIT_CH2};
   dsy_cfg #(.NCH(3), .SLOT_CYC(13)) dsy_cfg_inst (.*);
   dsy_mapper dsy_mapper_inst (.i_lclk(lclk), .i_run(run), .i_long_gap(long_gap), .i_bit(bseed[0]),
      .o_gclk(gclk), .o_data(gdata));
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #3.3;
      forever #62.5 lclk = ~lclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function dsy_byte_t rnd();
      seed = lfsr(seed);
      return seed[7:0];
   endfunction : rnd
   always @(posedge lclk) bseed <= lfsr(bseed);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input dsy_byte_t a, input dsy_byte_t d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input dsy_byte_t a, input dsy_byte_t e);
      q_rd.push_back(e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask : rd
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // captured bits noted as the mapper sends them, long gap asked once
   always @(posedge gclk) begin
      q_bit.push_back(gdata);
      nb++;
      long_gap <= (nb == 100);
   end
   // result watcher and hang guard
   always @(posedge i_clk) begin
      rd_d <= i_rd;
      cyc <= cyc + 1;
      if (rd_d) chk(o_rdata, q_rd.pop_front());
      if (o_line_strobe !== 3'b000) begin
         bq = q_bit.pop_front();
         chk({o_line_strobe, o_line_data}, {3'b111, {3{bq}}});
      end
      if (cyc == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (c = 0; c < 3; c++) begin
         v = rnd();
         rd(LADDR[c], 8'h00);
         rd(JADDR[c], 8'h00);
         wr(LADDR[c], 8'hFF);
         rd(LADDR[c], 8'h3F);
         wr(JADDR[c], v);
         rd(JADDR[c], v & 8'h1F);
      end
      wr(8'h08, 8'hFF);
      rd(8'h08, 8'h00);
      rd(`DSY_STATUS, 8'h80);
      for (int k = 0; k < 24; k++) begin
         c = k % 3;
         v = rnd();
         w = rnd();
         wr(LADDR[c], v);
         wr(JADDR[c], w);
         repeat (2) @(posedge i_clk);
         #1;
         chk(o_single_rail[c], v[0]);
         chk({o_ds3_mode[c], o_e3_mode[c], o_sts1_mode[c]}, {!(v[1] | v[2]), v[2], v[1] & !v[2]});
         chk({o_test_pattern_enable[c], o_far_loopback_enable[c], o_near_loopback_enable[c]}, v[5:3]);
         chk(o_narrow_bw[c], w[0] & !w[2]);
         chk({o_tx_path[c], o_attenuator_block_reset[c]}, {w[1], w[3]});
         chk(o_fast_recovery_on[c], !w[4]);
      end
      for (c = 0; c < 3; c++) wr(JADDR[c], 8'h10);
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clk);
         v = rnd();
         w = rnd();
         i_host_mode <= 1'b0;
         i_rail_format_select <= v[2:0];
         i_low_rate_select <= v[5:3];
         i_sonet_rate_select <= w[2:0];
         i_bandwidth_select_low <= w[5:3];
         i_bandwidth_select_high <= {v[7:6], w[6]};
         i_attenuator_path_select <= {w[7], v[7], v[0]};
         repeat (5) @(posedge i_clk);
         #1;
         chk(o_fast_recovery_on, 3'b111);
         chk(o_single_rail, v[2:0]);
      end
      @(posedge i_clk);
      i_host_mode <= 1'b1;
      wr(JADDR[0], 8'h03);
      run <= 1'b1;
      while (nb < 800) @(posedge i_clk);
      #1;
      chk(o_locked, 3'b111);
      rd(`DSY_STATUS, 8'h87);
      run <= 1'b0;
      repeat (1000) @(posedge i_clk);
      chk(o_locked, 3'b000);
      chk(8'(q_bit.size()), 8'h00);
      report_and_stop();
   end
endmodule : tb
